// ---- rtl/usc_regs.vh ----
// Register addresses, field positions and codes of the setup capture block.
`ifndef USC_REGS_VH
`define USC_REGS_VH
`define USC_ADDR_REQ_TYPE   8'hD0
`define USC_ADDR_SETUP_MASK 8'hF8
`define USC_ADDR_REQ_CODE   8'hD1
`define USC_ADDR_VALUE_LO   8'hD2
`define USC_ADDR_VALUE_HI   8'hD3
`define USC_ADDR_INDEX_LO   8'hD4
`define USC_ADDR_INDEX_HI   8'hD5
`define USC_ADDR_LENGTH_LO  8'hD6
`define USC_ADDR_LENGTH_HI  8'hD7
`define USC_ADDR_POL_RD     8'hD8
`define USC_ADDR_POL_WR     8'h58
`define USC_ADDR_SYSCTL_WR  8'h4F
`define USC_SYSCTL_SWRST    0
`define USC_SYSCTL_STOP_HI  7
`define USC_SYSCTL_STOP_LO  4
`define USC_STOP_CODE       4'hA
`define USC_POL_MASK        8'h07
`define USC_SETUP_BYTES     8
`endif

// ---- rtl/usc_setup_shift.v ----
// Collects one setup packet byte by byte and presents all eight together.
`timescale 1ns/1ps
`default_nettype none
module usc_setup_shift
(
	input  wire        sys_clk_i,   // System clock.
	input  wire        clear_i,     // Synchronous clear, active high.
	input  wire        byte_vld_i,  // Setup byte strobe.
	input  wire [7:0]  byte_i,      // Setup byte.
	input  wire        start_i,     // First byte of a packet.
	output reg  [63:0] pkt_o,       // Eight bytes, byte 0 in low bits.
	output reg         done_o       // Pulse when eight bytes are held.
);
	reg [63:0] sh_q;
	reg [3:0]  cnt_q;

	always @(posedge sys_clk_i)
	begin
		done_o <= 1'b0;
		if (clear_i)
		begin
			sh_q  <= 64'h0;
			cnt_q <= 4'h0;
			pkt_o <= 64'h0;
		end
		else if (byte_vld_i)
		begin
			sh_q <= {byte_i, sh_q[63:8]};
			if (start_i)
				cnt_q <= 4'h1;
			else if (cnt_q == 4'h7)
			begin
				pkt_o  <= {byte_i, sh_q[63:8]};
				done_o <= 1'b1;
				cnt_q  <= 4'h0;
			end
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/usc_top.v ----
// Setup request capture and system control of the device register port.
//
// Overview of operation
// - Software reset write clears setup capture, read port, FIFO grant and polarity select; oscillator and standby keep their state.
// - Code 1010b written to bits 7..4 of system control with bit 0 clear stops the oscillator.
// - While stopped, register access works but FIFO access is refused.
// - Reset pin restarts the oscillator; host must reconnect and re-enumerate.
// - Eight setup bytes are stored automatically during the setup stage while the oscillator runs.
// - Request code byte reads at address D1h.
// - Value, index and length bytes read at D2h through D7h.
// - Setup registers are read only, written solely by received setup stages.
// - Polarity select bits 7..3 always read zero; written ones are dropped.
`timescale 1ns/1ps
`default_nettype none
`include "usc_regs.vh"
module usc_top
(
	input  wire       sys_clk_i,       // 100 MHz clock.
	input  wire       reset_n_i,       // Hardware reset pin, active low.
	input  wire       bus_reset_i,     // USB bus reset, same-clock level.
	input  wire       cs_n_i,          // Chip select pin, active low.
	input  wire       rd_n_i,          // Read strobe pin, active low.
	input  wire       wr_n_i,          // Write strobe pin, active low.
	input  wire [7:0] addr_i,          // Register address pins.
	input  wire [7:0] wdata_i,         // Write data pins.
	input  wire       setup_vld_i,     // Setup byte strobe from the link.
	input  wire [7:0] setup_byte_i,    // Setup byte from the link.
	input  wire       setup_start_i,   // First setup byte marker.
	input  wire       fifo_req_i,      // Local FIFO access request.
	output reg  [7:0] rdata_o,         // Read data.
	output reg        rdata_oe_n_o,    // Data bus output enable, active low.
	output reg        osc_run_o,       // Oscillator enable.
	output reg        standby_o,       // Standby indication.
	output reg        fifo_grant_o,    // FIFO access granted.
	output reg        setup_ready_o,   // Pulse when a setup packet is stored.
	output reg  [2:0] pol_sel_o        // Polarity select bits.
);
	// ********************************
	// Pin synchronisers
	// ********************************
	reg       cs_s1_q;
	reg       cs_s2_q;
	reg       rd_s1_q;
	reg       rd_s2_q;
	reg       wr_s1_q;
	reg       wr_s2_q;
	reg [7:0] a_s1_q;
	reg [7:0] a_s2_q;
	reg [7:0] d_s1_q;
	reg [7:0] d_s2_q;
	reg       wr_prev_q;

	// Strobe stages reset to the idle high level, so no false write edge follows reset.
	always @(posedge sys_clk_i)
	begin
		if (~reset_n_i)
		begin
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			rd_s1_q   <= 1'b1;
			rd_s2_q   <= 1'b1;
			wr_s1_q   <= 1'b1;
			wr_s2_q   <= 1'b1;
			wr_prev_q <= 1'b1;
		end
		else
		begin
			cs_s1_q   <= cs_n_i;
			cs_s2_q   <= cs_s1_q;
			rd_s1_q   <= rd_n_i;
			rd_s2_q   <= rd_s1_q;
			wr_s1_q   <= wr_n_i;
			wr_s2_q   <= wr_s1_q;
			wr_prev_q <= wr_s2_q;
		end
	end

	// Address and data stages need no reset; they are only used under a strobe.
	always @(posedge sys_clk_i)
	begin
		a_s1_q <= addr_i;
		a_s2_q <= a_s1_q;
		d_s1_q <= wdata_i;
		d_s2_q <= d_s1_q;
	end

	wire sel   = ~cs_s2_q;
	wire rd_en = sel & ~rd_s2_q;
	// Write acts on the falling edge of the write pulse.
	wire wr_pl = sel & ~wr_s2_q & wr_prev_q;

	// ********************************
	// Reset sources and write decodes
	// ********************************
	function is_sysctl;
		input [7:0] a;
		begin
			is_sysctl = (a == `USC_ADDR_SYSCTL_WR);
		end
	endfunction

	function wdata_sw_bit;
		input [7:0] d;
		begin
			wdata_sw_bit = d[`USC_SYSCTL_SWRST];
		end
	endfunction

	function is_stop_code;
		input [7:0] d;
		begin
			is_stop_code = (d[`USC_SYSCTL_STOP_HI:`USC_SYSCTL_STOP_LO] == `USC_STOP_CODE);
		end
	endfunction

	wire sysctl_wr = wr_pl & is_sysctl(a_s2_q);
	wire sw_rst    = sysctl_wr & wdata_sw_bit(d_s2_q);
	wire stop_cmd  = sysctl_wr & is_stop_code(d_s2_q);
	wire pol_wr    = wr_pl & (a_s2_q == `USC_ADDR_POL_WR);
	wire hw_clr    = ~reset_n_i | sw_rst;
	wire setup_clr = hw_clr | bus_reset_i;

	// ********************************
	// Setup capture
	// ********************************
	wire [63:0] pkt;
	wire        pkt_done;
	usc_setup_shift u_shift
	(
		.sys_clk_i  (sys_clk_i),
		.clear_i    (setup_clr),
		.byte_vld_i (setup_vld_i & osc_run_o),
		.byte_i     (setup_byte_i),
		.start_i    (setup_start_i),
		.pkt_o      (pkt),
		.done_o     (pkt_done)
	);

	// ********************************
	// Control state
	// ********************************
	always @(posedge sys_clk_i)
	begin
		if (~reset_n_i)
		begin
			osc_run_o <= 1'b1;
			standby_o <= 1'b0;
			pol_sel_o <= 3'h0;
		end
		else if (sw_rst)
		begin
			pol_sel_o <= 3'h0;
		end
		else
		begin
			if (stop_cmd)
			begin
				osc_run_o <= 1'b0;
				standby_o <= 1'b1;
			end
			if (pol_wr)
				pol_sel_o <= d_s2_q[2:0];
		end
	end

	// ********************************
	// Register read decode and mux
	// ********************************
	function [7:0] pick;
		input [63:0] p;
		input [2:0]  i;
		begin
			pick = p[{i, 3'b000} +: 8];
		end
	endfunction

	function is_setup_addr;
		input [7:0] a;
		begin
			is_setup_addr = ((a & `USC_ADDR_SETUP_MASK) == `USC_ADDR_REQ_TYPE);
		end
	endfunction

	// Read mux: the setup window first, then the polarity read address.
	reg [7:0] rd_d;
	always @*
	begin
		rd_d = 8'h00;
		if (is_setup_addr(a_s2_q))
			rd_d = pick(pkt, a_s2_q[2:0]);
		else if (a_s2_q == `USC_ADDR_POL_RD)
			rd_d = {5'h00, pol_sel_o} & `USC_POL_MASK;
		else
			rd_d = 8'h00;
	end

	// ********************************
	// Read port
	// ********************************
	// Read data returns to zero whenever no read is in progress.
	always @(posedge sys_clk_i)
	begin
		if (hw_clr)
		begin
			rdata_o      <= 8'h00;
			rdata_oe_n_o <= 1'b1;
		end
		else
		begin
			rdata_o      <= rd_en ? rd_d : 8'h00;
			rdata_oe_n_o <= ~rd_en;
		end
	end

	// ********************************
	// FIFO gating and setup status
	// ********************************
	// FIFO access is refused for as long as the oscillator is stopped.
	always @(posedge sys_clk_i)
	begin
		if (hw_clr)
		begin
			fifo_grant_o  <= 1'b0;
			setup_ready_o <= 1'b0;
		end
		else
		begin
			fifo_grant_o  <= fifo_req_i & osc_run_o;
			setup_ready_o <= pkt_done;
		end
	end
endmodule
`default_nettype wire

// ---- test/usc_top_properties.sv ----
// Port checks of the setup capture block.
`timescale 1ns/1ps
`default_nettype none
module usc_top_properties
(
	input wire logic       sys_clk_i,     // Clock.
	input wire logic       reset_n_i,     // Reset.
	input wire logic       setup_vld_i,   // Strobe.
	input wire logic       fifo_req_i,    // Request.
	input wire logic       osc_run_o,     // Running.
	input wire logic       standby_o,     // Standby.
	input wire logic       fifo_grant_o,  // Grant.
	input wire logic       setup_ready_o, // Stored.
	input wire logic [2:0] pol_sel_o      // Polarity.
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_stop; $fell(osc_run_o) |-> standby_o; endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_sb; standby_o |-> !osc_run_o; endproperty
	a_sb: assert property (p_sb) else $error("sb");
	property p_hold; standby_o |=> standby_o; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_rst; $rose(reset_n_i) |-> osc_run_o && !standby_o && pol_sel_o==3'h0; endproperty
	a_rst: assert property (p_rst) else $error("rst");
	property p_rdy; setup_ready_o |-> $past(setup_vld_i,2); endproperty
	a_rdy: assert property (p_rdy) else $error("rdy");
	property p_pls; setup_ready_o |=> !setup_ready_o; endproperty
	a_pls: assert property (p_pls) else $error("pls");
	property p_gnt; fifo_grant_o |-> $past(fifo_req_i) && $past(osc_run_o); endproperty
	a_gnt: assert property (p_gnt) else $error("gnt");
	property p_gst; standby_o |=> !fifo_grant_o; endproperty
	a_gst: assert property (p_gst) else $error("gst");
endmodule
bind usc_top usc_top_properties i_props(.sys_clk_i, .reset_n_i, .setup_vld_i, .fifo_req_i,
	.osc_run_o, .standby_o, .fifo_grant_o, .setup_ready_o, .pol_sel_o);
`default_nettype wire

// ---- test/usc_host_model.sv ----
// Host model that sends setup stage bytes.
`timescale 1ns/1ps
`default_nettype none
module usc_host_model
(
	input  wire logic       sys_clk_i, // Clock.
	output var  logic       vld_o=0,   // Strobe.
	output var  logic [7:0] byte_o=0,  // Byte.
	output var  logic       start_o=0  // First byte.
);
	// Sends n bytes of one request in order, then scrambles the line.
	task automatic send(input logic [63:0] p, input int n);
		for (int i=0; i<n; i++)
		begin
			@(negedge sys_clk_i);
			vld_o=1;
			start_o=(i==0);
			byte_o=p[8*i+:8];
		end
		@(negedge sys_clk_i);
		vld_o=0;
		start_o=0;
		byte_o=~byte_o;
	endtask
endmodule
`default_nettype wire

// ---- test/usc_top_bench.sv ----
// Bench of the setup capture block.
`timescale 1ns/1ps
`default_nettype none
module usc_top_bench;
	logic c=0, r=0, cs=1, rn=1, wn=1, fq=0, br=0, v, st, oe, osc, sb, fg, rdy;
	logic [7:0] a=0, wd=0, rd, b;
	logic [2:0] pol;
	int bad_count=0, compares=0, cyc=0;
	initial forever #5 c=~c;
	usc_host_model i_host(.sys_clk_i(c), .vld_o(v), .byte_o(b), .start_o(st));
	usc_top i_dut(.sys_clk_i(c), .reset_n_i(r), .bus_reset_i(br), .cs_n_i(cs), .rd_n_i(rn),
		.wr_n_i(wn), .addr_i(a), .wdata_i(wd), .setup_vld_i(v), .setup_byte_i(b),
		.setup_start_i(st), .fifo_req_i(fq), .rdata_o(rd), .rdata_oe_n_o(oe), .osc_run_o(osc),
		.standby_o(sb), .fifo_grant_o(fg), .setup_ready_o(rdy), .pol_sel_o(pol));
	task automatic chk(input logic [7:0] g, e);
		compares++;
		if (g!==e)
		begin
			bad_count++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] ad, d, e);
		@(negedge c);
		a=ad;
		wd=d;
		cs=0;
		rn=w;
		wn=!w;
		repeat (4) @(negedge c);
		if (!w) chk(rd, e);
		if (!w) chk({7'h00, oe}, 8'h00);
		cs=1;
		rn=1;
		wn=1;
		repeat (4) @(negedge c);
		chk({7'h00, oe}, 8'h01);
	endtask
	task t_setup;
		acc(0, 8'hD1, 0, 0);
		i_host.send(64'h0706050403020180, 8);
		acc(0, 8'hD0, 0, 8'h80);
		for (int i=1; i<8; i++) acc(0, 8'hD0+i, 0, i);
		acc(1, 8'hD3, 8'hFF, 0);
		acc(0, 8'hD3, 0, 3);
		i_host.send(64'hFFFFFFFFFFFFFFFF, 5);
		acc(0, 8'hD2, 0, 2);
		br=1;
		@(negedge c);
		br=0;
		acc(0, 8'hD2, 0, 0);
	endtask
	task t_pol;
		acc(1, 8'h58, 8'hFF, 0);
		acc(0, 8'hD8, 0, 8'h07);
		acc(1, 8'h4F, 8'h01, 0);
		acc(0, 8'hD1, 0, 0);
		chk(pol, 0);
	endtask
	task t_stop;
		fq=1;
		acc(1, 8'h4F, 8'hA0, 0);
		chk({osc, sb, fg}, 3'b010);
		acc(1, 8'h58, 8'h05, 0);
		acc(0, 8'hD8, 0, 5);
		r=0;
		repeat (3) @(negedge c);
		r=1;
		repeat (3) @(negedge c);
		chk({osc, sb, fg}, 3'b101);
	endtask
	task test_done;
		if (bad_count==0 && compares>0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge c)
	begin
		cyc++;
		if (cyc==3000)
		begin
			bad_count++;
			test_done;
		end
	end
	initial
	begin
		repeat (10) @(negedge c);
		r=1;
		repeat (3) @(negedge c);
		t_setup;
		t_pol;
		t_stop;
		test_done;
	end
endmodule
`default_nettype wire
